// >>> rtl/cpues_device.sv
// Processor end of the error and init sideband
//
// Summary of operation
// - No stop request: pin flags unmasked FP error
// - Stop request: same pin flags pending break
// - Both snoop lines together request a stall
// - Snoop lines driven and sampled on set edges
// - Internal error raises pin and halt cycle
// - Core logic always turns halt into an NMI on nmiOut
// - Ignore input set: pending FP error ignored
// - Ignore input clear: FP instruction takes exception
// - Native report bit set: ignore input disregarded
// - Ignore input taken through a two-flop sync, target-ready unused
// - Warm restart clears integer regs, keeps caches
// - Warm restart resumes at configured reset vector
// - Snoops still served during warm restart
// - Warm restart at reset release runs self-test
`timescale 1ns/10ps
module cpues_device #(
  parameter logic [31:0] RESET_VECTOR = 32'hFFFF_FFF0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  cpues_if.device bus,
  input wire logic fpErrorDetect,
  input wire logic fpErrorUnmasked,
  input wire logic breakPending,
  input wire logic internalErrorDetect,
  input wire logic cr0FaultReportBit,
  input wire logic fpInstrIssue,
  input wire logic snoopReq,
  input wire logic snoopHitLocal,
  input wire logic snoopHitModLocal,
  input wire logic snoopStallLocal,
  output logic fpException,
  output logic fpErrorPending,
  output logic integerRegsClear,
  output logic [31:0] fetchAddress,
  output logic selfTestRun,
  output logic [1:0] snoopResult,
  output logic snoopResultValid
);
  import cpues_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] ignSync_q, ignSync_d, initSync_q, initSync_d;
  logic rstSeen_q, rstSeen_d;
  logic ferr_q, ferr_d, internal_fault_out_q, internal_fault_out_d, halt_q, halt_d;
  logic fpPend_q, fpPend_d, fpExc_q, fpExc_d;
  logic intClr_q, intClr_d, power_on_selftest_q, power_on_selftest_d;
  logic [31:0] fetch_q, fetch_d;
  logic [1:0] snpPh_q, snpPh_d;
  logic hitO_q, hitO_d, hitmO_q, hitmO_d, snpOe_q, snpOe_d;
  logic [1:0] snpRes_q, snpRes_d;
  logic snpVal_q, snpVal_d;
  logic ignEff, initLvl;

  // Only the second stage is read by logic
  assign ignEff = ignSync_q[1] & ~cr0FaultReportBit;
  assign initLvl = initSync_q[1];

  always_comb begin
    ignSync_d = {ignSync_q[0], bus.numericFaultIgnoreIn};
    initSync_d = {initSync_q[0], bus.warmRestartIn};
    rstSeen_d = bus.mainReset;
    ferr_d = bus.stopClockRequest ? breakPending
      : (fpPend_q | (fpErrorDetect & fpErrorUnmasked));
    fpPend_d = fpPend_q | (fpErrorDetect & fpErrorUnmasked);
    fpExc_d = 1'b0;
    if (fpInstrIssue && fpPend_q && !ignEff) begin
      fpExc_d = 1'b1;
      fpPend_d = 1'b0;
    end
    // With ignore active the error stays pending but execution goes on
    internal_fault_out_d = internal_fault_out_q | internalErrorDetect;
    halt_d = internalErrorDetect & ~internal_fault_out_q;
    if (bus.mainReset || bus.busRestartIn || initLvl) begin
      internal_fault_out_d = internalErrorDetect;
    end
    intClr_d = initLvl;
    fetch_d = initLvl ? RESET_VECTOR : fetch_q;
    if (initLvl) begin
      fpPend_d = fpPend_q;
    end
    power_on_selftest_d = power_on_selftest_q;
    if (rstSeen_q && !bus.mainReset) begin
      power_on_selftest_d = initLvl;
    end
    // Snoop phase continues regardless of warm restart
    snpPh_d = snpPh_q;
    hitO_d = hitO_q;
    hitmO_d = hitmO_q;
    snpOe_d = snpOe_q;
    snpRes_d = snpRes_q;
    snpVal_d = 1'b0;
    case (snpPh_q)
      2'd0: begin
        if (snoopReq) begin
          snpPh_d = 2'd1;
          hitO_d = snoopHitLocal | snoopStallLocal;
          hitmO_d = snoopHitModLocal | snoopStallLocal;
          snpOe_d = 1'b1;
        end
      end
      2'd1: begin
        snpPh_d = 2'd2;
      end
      2'd2: begin
        // Sample two edges after drive so all agents settle
        snpVal_d = 1'b1;
        snpOe_d = 1'b0;
        snpRes_d = {bus.snoopMatchModifiedFlagWire, bus.snoopHitWire};
        if (bus.snoopHitWire && bus.snoopMatchModifiedFlagWire) begin
          // A stall from any agent is no result: sample again later
          snpVal_d = 1'b0;
          snpPh_d = 2'd1;
          hitO_d = snoopStallLocal;
          hitmO_d = snoopStallLocal;
          snpOe_d = snoopStallLocal;
        end else begin
          snpPh_d = 2'd0;
          hitO_d = 1'b0;
          hitmO_d = 1'b0;
        end
      end
      default: snpPh_d = 2'd0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ignSync_q <= 2'b00;
      initSync_q <= 2'b00;
      rstSeen_q <= 1'b0;
      ferr_q <= 1'b0;
      fpPend_q <= 1'b0;
      fpExc_q <= 1'b0;
      internal_fault_out_q <= 1'b0;
      halt_q <= 1'b0;
      intClr_q <= 1'b0;
      fetch_q <= 32'h0000_0000;
      power_on_selftest_q <= 1'b0;
      snpPh_q <= 2'd0;
      hitO_q <= 1'b0;
      hitmO_q <= 1'b0;
      snpOe_q <= 1'b0;
      snpRes_q <= 2'b00;
      snpVal_q <= 1'b0;
    end else if (clkEn) begin
      ignSync_q <= ignSync_d;
      initSync_q <= initSync_d;
      rstSeen_q <= rstSeen_d;
      ferr_q <= ferr_d;
      fpPend_q <= fpPend_d;
      fpExc_q <= fpExc_d;
      internal_fault_out_q <= internal_fault_out_d;
      halt_q <= halt_d;
      intClr_q <= intClr_d;
      fetch_q <= fetch_d;
      power_on_selftest_q <= power_on_selftest_d;
      snpPh_q <= snpPh_d;
      hitO_q <= hitO_d;
      hitmO_q <= hitmO_d;
      snpOe_q <= snpOe_d;
      snpRes_q <= snpRes_d;
      snpVal_q <= snpVal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus.faultOrBreakPending = ferr_q;
  assign bus.internalFaultOut = internal_fault_out_q;
  assign bus.haltBusCycle = halt_q;
  assign bus.snoopHitDevO = hitO_q;
  assign bus.snoopHitDevOe = snpOe_q;
  assign bus.snoopMatchModifiedFlagDevO = hitmO_q;
  assign bus.snoopMatchModifiedFlagDevOe = snpOe_q;
  assign fpException = fpExc_q;
  assign fpErrorPending = fpPend_q;
  assign integerRegsClear = intClr_q;
  assign fetchAddress = fetch_q;
  assign selfTestRun = power_on_selftest_q;
  assign snoopResult = snpRes_q;
  assign snoopResultValid = snpVal_q;
endmodule

// >>> rtl/cpues_if.sv
// Sideband wires between the processor end and the core logic end
`timescale 1ns/10ps
interface cpues_if;
  logic faultOrBreakPending;
  logic stopClockRequest;
  logic internalFaultOut;
  logic numericFaultIgnoreIn;
  logic warmRestartIn;
  logic busRestartIn;
  logic mainReset;
  logic haltBusCycle;
  logic targetReadyPhase;
  logic snoopHitDevO;
  logic snoopHitDevOe;
  logic snoopMatchModifiedFlagDevO;
  logic snoopMatchModifiedFlagDevOe;
  logic snoopHitSysO;
  logic snoopHitSysOe;
  logic snoopMatchModifiedFlagSysO;
  logic snoopMatchModifiedFlagSysOe;
  logic snoopHitWire;
  logic snoopMatchModifiedFlagWire;
  // Wire-OR resolution of the shared snoop lines
  assign snoopHitWire = (snoopHitDevOe & snoopHitDevO) | (snoopHitSysOe & snoopHitSysO);
  assign snoopMatchModifiedFlagWire = (snoopMatchModifiedFlagDevOe & snoopMatchModifiedFlagDevO)
    | (snoopMatchModifiedFlagSysOe & snoopMatchModifiedFlagSysO);
  modport device (
    output faultOrBreakPending, internalFaultOut, haltBusCycle,
    output snoopHitDevO, snoopHitDevOe, snoopMatchModifiedFlagDevO, snoopMatchModifiedFlagDevOe,
    input stopClockRequest, numericFaultIgnoreIn, warmRestartIn, busRestartIn, mainReset,
    input targetReadyPhase, snoopHitWire, snoopMatchModifiedFlagWire
  );
  modport system (
    input faultOrBreakPending, internalFaultOut, haltBusCycle,
    output snoopHitSysO, snoopHitSysOe, snoopMatchModifiedFlagSysO, snoopMatchModifiedFlagSysOe,
    output stopClockRequest, numericFaultIgnoreIn, warmRestartIn, busRestartIn, mainReset,
    output targetReadyPhase,
    input snoopHitWire, snoopMatchModifiedFlagWire
  );
endinterface

// >>> rtl/cpues_pkg.sv
// Shared constants and types for the processor error and init sideband
package cpues_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SNOOP_PHASE_LEN = 2;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_MASK = 32'h0000_0008;
  localparam logic [31:0] ADDR_SNOOP = 32'h0000_000C;
  localparam int unsigned CTRL_IGN_BIT = 0;
  localparam int unsigned CTRL_INIT_BIT = 1;
  localparam int unsigned CTRL_STOP_CLOCK_REQUEST_BIT = 2;
  localparam int unsigned CTRL_BUS_RESTART_IN_BIT = 3;
  localparam int unsigned ST_INTERNAL_FAULT_OUT_BIT = 0;
  localparam int unsigned ST_SHUT_BIT = 1;
  localparam int unsigned ST_FERR_BIT = 2;
  localparam int unsigned ST_STALL_BIT = 3;
  localparam int unsigned ST_POWER_ON_SELFTEST_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  typedef enum logic [1:0] {SNOOP_NONE, SNOOP_HIT, SNOOP_SNOOP_MATCH_MODIFIED_FLAG, SNOOP_STALL} cpues_snoop_t;
endpackage

// >>> rtl/cpues_system.sv
// Core logic end of the error and init sideband, with APB registers
`timescale 1ns/10ps
module cpues_system (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  cpues_if.system bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic nmiOut
);
  import cpues_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q, ctrl_d, prdata_q, prdata_d;
  logic [4:0] status_q, status_d, mask_q, mask_d, ev;
  logic ierrPrev_q, ferrPrev_q, stall_q, stall_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d, nmi_q, nmi_d;
  logic wr, rd, mapped;

  assign wr = psel & penable & pwrite & pready_q;
  assign rd = psel & ~penable & ~pwrite;
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_MASK)
    | (paddr == ADDR_SNOOP);

  always_comb begin
    ev = '0;
    ev[ST_INTERNAL_FAULT_OUT_BIT] = bus.internalFaultOut & ~ierrPrev_q;
    ev[ST_SHUT_BIT] = bus.haltBusCycle;
    ev[ST_FERR_BIT] = bus.faultOrBreakPending & ~ferrPrev_q;
    ev[ST_STALL_BIT] = bus.snoopHitWire & bus.snoopMatchModifiedFlagWire;
    ev[ST_POWER_ON_SELFTEST_BIT] = 1'b0;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    status_d = status_q;
    if (wr && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata;
    end
    if (wr && paddr == ADDR_MASK) begin
      mask_d = pwdata[4:0];
    end
    if (wr && paddr == ADDR_STATUS) begin
      status_d = status_q & ~pwdata[4:0];
    end
    // Set beats clear
    status_d = status_d | ev;
    pready_d = psel & ~penable;
    pslverr_d = psel & ~penable & ~mapped;
    prdata_d = prdata_q;
    if (rd) begin
      case (paddr)
        ADDR_CTRL: prdata_d = ctrl_q;
        ADDR_STATUS: prdata_d = {27'h000_0000, status_q};
        ADDR_MASK: prdata_d = {27'h000_0000, mask_q};
        ADDR_SNOOP: prdata_d = {29'h0000_0000, stall_q, bus.snoopMatchModifiedFlagWire,
          bus.snoopHitWire};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(status_d & mask_d);
    // Halt cycle always turned into a non-maskable interrupt
    nmi_d = bus.haltBusCycle;
    stall_d = ev[ST_STALL_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET[4:0];
      status_q <= STATUS_RESET;
      ierrPrev_q <= 1'b0;
      ferrPrev_q <= 1'b0;
      stall_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      nmi_q <= 1'b0;
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      status_q <= status_d;
      ierrPrev_q <= bus.internalFaultOut;
      ferrPrev_q <= bus.faultOrBreakPending;
      stall_q <= stall_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      nmi_q <= nmi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drives a stall on both snoop lines for as long as ctrl bit 4 is set
  assign bus.snoopHitSysO = ctrl_q[4];
  assign bus.snoopMatchModifiedFlagSysO = ctrl_q[4];
  assign bus.snoopHitSysOe = ctrl_q[4];
  assign bus.snoopMatchModifiedFlagSysOe = ctrl_q[4];
  assign bus.numericFaultIgnoreIn = ctrl_q[CTRL_IGN_BIT];
  assign bus.warmRestartIn = ctrl_q[CTRL_INIT_BIT];
  assign bus.stopClockRequest = ctrl_q[CTRL_STOP_CLOCK_REQUEST_BIT];
  assign bus.busRestartIn = ctrl_q[CTRL_BUS_RESTART_IN_BIT];
  assign bus.mainReset = ctrl_q[5];
  assign bus.targetReadyPhase = ctrl_q[6];
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign nmiOut = nmi_q;
endmodule

// >>> tb/cpu_error_init_sideband_tb.sv
// Bench joining both ends of the sideband
`timescale 1ns/10ps
module cpu_error_init_sideband_tb;
  import cpues_pkg::*;
  localparam logic [31:0] VEC = 32'h0000_1230;
  localparam logic [31:0] CLRS [3] = '{32'h0000_0008, 32'h0000_0002, 32'h0000_0020};
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, internal_fault_out = 0, cr0 = 0, iss = 0;
  logic fpErr = 0, fpUnm = 0, brk = 0, sReq = 0, sHit = 0, sHitm = 0, excS = 0, vldS = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, fetch;
  logic pready, pslverr, irq, nmiOut, exc, pend, regClr, err, power_on_selftest, sval, nmiS = 0;
  logic [1:0] sres, resS;
  int mismatches = 0, nTests = 0, cyc = 0;
  cpues_if bif ();
  cpues_device #(.RESET_VECTOR(VEC)) i_cpues_device (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
    .bus(bif), .fpErrorDetect(fpErr), .fpErrorUnmasked(fpUnm), .breakPending(brk),
    .internalErrorDetect(internal_fault_out), .cr0FaultReportBit(cr0), .fpInstrIssue(iss), .snoopReq(sReq),
    .snoopHitLocal(sHit), .snoopHitModLocal(sHitm), .snoopStallLocal(1'b0), .fpException(exc),
    .fpErrorPending(pend), .integerRegsClear(regClr), .fetchAddress(fetch),
    .selfTestRun(power_on_selftest), .snoopResult(sres), .snoopResultValid(sval));
  cpues_system i_cpues_system (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .bus(bif),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .nmiOut(nmiOut));
  cpues_assertions i_cpues_assertions (.clk(clk), .rst_n(rst_n),
    .internalFaultOut(bif.internalFaultOut), .haltBusCycle(bif.haltBusCycle),
    .mainReset(bif.mainReset), .busRestartIn(bif.busRestartIn),
    .warmRestartIn(bif.warmRestartIn), .snoopHitDevO(bif.snoopHitDevO),
    .snoopHitDevOe(bif.snoopHitDevOe), .snoopHitWire(bif.snoopHitWire),
    .snoopMatchModifiedFlagDevO(bif.snoopMatchModifiedFlagDevO),
    .snoopMatchModifiedFlagDevOe(bif.snoopMatchModifiedFlagDevOe),
    .snoopMatchModifiedFlagWire(bif.snoopMatchModifiedFlagWire));
  ////////////////////////////////////////
  always #50 clk = ~clk;
  // Pulses are caught here so no check hangs on their exact cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (exc === 1'b1) excS <= 1'b1;
    if (nmiOut === 1'b1) nmiS <= 1'b1;
    if (sval === 1'b1) vldS <= 1'b1;
    if (sval === 1'b1) resS <= sres;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic pin(input logic [31:0] c, input logic e, input logic b, input logic u);
    apb('1, ADDR_CTRL, c);
    fpErr <= e;
    brk <= b;
    fpUnm <= u;
    idle(6);
  endtask
  task automatic tFerr();
    pin('0, '1, '1, '0);
    chk(bif.faultOrBreakPending, 1'b0);
    pin(32'h0000_0004, '0, '1, '0);
    chk(bif.faultOrBreakPending, 1'b1);
    pin(32'h0000_0004, '0, '0, '0);
    chk(bif.faultOrBreakPending, 1'b0);
    pin('0, '1, '0, '1);
    chk(bif.faultOrBreakPending, 1'b1);
    fpErr <= 1'b0;
    $display("error pin done");
  endtask
  task automatic fpCase(input logic [31:0] c, input logic n, input logic e);
    pin(c, '1, '0, '1);
    fpErr <= 1'b0;
    cr0 <= n;
    excS <= 1'b0;
    idle(4);
    iss <= 1'b1;
    @(posedge clk);
    iss <= 1'b0;
    idle(6);
    chk(excS, e);
  endtask
  task automatic tIerr();
    apb('0, 32'h0000_0010, '0);
    chk(err, 1'b1);
    apb('1, ADDR_STATUS, 32'h0000_001F);
    chk(irq, 1'b0);
    foreach (CLRS[i]) begin
      nmiS <= 1'b0;
      internal_fault_out <= 1'b1;
      @(posedge clk);
      internal_fault_out <= 1'b0;
      idle(20);
      chk(bif.internalFaultOut, 1'b1);
      chk(nmiS, 1'b1);
      apb('0, ADDR_STATUS, '0);
      chk(rd[ST_INTERNAL_FAULT_OUT_BIT], 1'b1);
      chk(rd[ST_SHUT_BIT], 1'b1);
      chk(irq, 1'b0);
      apb('1, ADDR_MASK, 32'hFFFF_FFFF);
      chk(irq, 1'b1);
      apb('1, ADDR_MASK, '0);
      apb('1, ADDR_STATUS, 32'h0000_001F);
      chk(irq, 1'b0);
      apb('1, ADDR_CTRL, CLRS[i]);
      idle(6);
      apb('1, ADDR_CTRL, '0);
      idle(6);
      chk(bif.internalFaultOut, 1'b0);
    end
    $display("internal error done");
  endtask
  task automatic snoop(input logic h, input logic m, input logic [1:0] r);
    sHit <= h;
    sHitm <= m;
    vldS <= 1'b0;
    sReq <= 1'b1;
    @(posedge clk);
    sReq <= 1'b0;
    idle(12);
    chk(vldS, r != 2'b11);
    if (r != 2'b11) chk(resS, r);
  endtask
  task automatic tInit();
    chk(power_on_selftest, 1'b0);
    pin(32'h0000_0002, '1, '0, '1);
    fpErr <= 1'b0;
    chk(regClr, 1'b1);
    chk(fetch, VEC);
    chk(pend, 1'b1);
    snoop('1, '0, 2'b01);
    apb('1, ADDR_CTRL, 32'h0000_0022);
    idle(4);
    apb('1, ADDR_CTRL, 32'h0000_0002);
    idle(4);
    chk(power_on_selftest, 1'b1);
    $display("warm restart done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tFerr();
    fpCase(32'h0000_0001, '0, '0);
    fpCase(32'h0000_0001, '1, '1);
    fpCase('0, '0, '1);
    tIerr();
    snoop('1, '0, 2'b01);
    snoop('0, '1, 2'b10);
    apb('1, ADDR_CTRL, 32'h0000_0010);
    snoop('0, '0, 2'b11);
    apb('1, ADDR_CTRL, '0);
    idle(8);
    chk(vldS, 1'b1);
    tInit();
    print_verdict();
  end
endmodule

// >>> tb/cpues_assertions.sv
// Checker on the wires between the two ends of the sideband
`timescale 1ns/10ps
module cpues_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic internalFaultOut,
  input wire logic haltBusCycle,
  input wire logic mainReset,
  input wire logic busRestartIn,
  input wire logic warmRestartIn,
  input wire logic snoopHitDevO,
  input wire logic snoopHitDevOe,
  input wire logic snoopMatchModifiedFlagDevO,
  input wire logic snoopMatchModifiedFlagDevOe,
  input wire logic snoopHitWire,
  input wire logic snoopMatchModifiedFlagWire
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic clr;
  logic stall;
  assign clr = mainReset | busRestartIn | warmRestartIn;
  assign stall = snoopHitWire & snoopMatchModifiedFlagWire;
  ////////////////////////////////////////
  // Four cycles, since restart inputs may pass a two-flop sync
  property p_faultHold;
    (internalFaultOut && !clr) [*4] |=> internalFaultOut;
  endproperty
  a_faultHold: assert property (p_faultHold) else $error("fault pin fell");
  property p_mainClr;
    mainReset [*5] |-> !internalFaultOut;
  endproperty
  a_mainClr: assert property (p_mainClr) else $error("fault kept in reset");
  property p_busClr;
    busRestartIn [*5] |-> !internalFaultOut;
  endproperty
  a_busClr: assert property (p_busClr) else $error("fault kept in restart");
  property p_haltAfter;
    $rose(internalFaultOut) |-> ##[0:8] haltBusCycle;
  endproperty
  a_haltAfter: assert property (p_haltAfter) else $error("no halt cycle");
  property p_haltCause;
    $rose(haltBusCycle) |-> ##[0:1] internalFaultOut;
  endproperty
  a_haltCause: assert property (p_haltCause) else $error("halt without fault");
  property p_hitHold;
    $rose(snoopHitDevOe) |=> snoopHitDevOe && $stable(snoopHitDevO);
  endproperty
  a_hitHold: assert property (p_hitHold) else $error("hit moved");
  property p_hitmHold;
    $rose(snoopMatchModifiedFlagDevOe) |=> $stable(snoopMatchModifiedFlagDevO);
  endproperty
  a_hitmHold: assert property (p_hitmHold) else $error("snoop_match_modified_flag moved");
  property p_snoopEnd;
    $rose(snoopHitDevOe) ##1 !stall |=> !snoopHitDevOe;
  endproperty
  a_snoopEnd: assert property (p_snoopEnd) else $error("drive too long");
  c_fault: cover property ($rose(internalFaultOut));
  c_stall: cover property (stall);
  c_snoop: cover property ($rose(snoopHitDevOe) ##2 !snoopHitDevOe);
endmodule
